/* verilog/lvdc_top.sv */
// Low-voltage detector control: mode and level registers, reset and irq
//
// Functional notes
// [R1] Software writes the level register only as a whole byte.
// [R2] Resets other than detector reset clear the level register.
// [R3] A detector reset leaves the level register unchanged.
// [R4] Level holds a 4-bit code; 0..9 valid, highest to lowest threshold.
// [R5] Software writes zeros to level register bits 7 to 4.
// [R6] Reset mode: assert internal reset while supply is below threshold.
// [R7] Interrupt mode: raise interrupt request while supply is below threshold.
// [R8] Reset start: mask, level, enable, wait 0.2 ms, check flag, set mode.
// [R9] Irq start: mask, level, enable, wait, check, clear pending, unmask.
// [R10] No reset when mode set while supply is at or above threshold.
// [R11] Unmasked, an interrupt may follow enabling at once.
// [R12] Stop reset mode: write zero, or clear mode bit then enable.
// [R13] Stop irq mode: write zero or clear the enable bit.
// [R14] Any reset sets the detector interrupt mask bit.
// [R15] During settling, the flag and pending request may be set.
// [R16] Service routine checks flag, then clears pending bit 1 of flag reg 0.
// [R17] A detector reset sets reset-cause bit 0.
// [R18] Mode register: enable bit 7, mode bit 1, read-only flag bit 0.
// [R19] Flag drives interrupt only while enabled and mode bit is zero.
// [R20] A detector reset leaves the mode register unchanged.
// [R21] Comparator output passes two flip-flops before use.
`timescale 1ns/1ps
module lvdc_top (
	// Clock and resets
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        detector_reset_n,
	// Register access
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_bit_wr,
	input  wire logic [2:0]  reg_bit_sel,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Analog side
	input  wire logic        cmp_below,
	output logic             cmp_enable,
	output logic      [3:0]  detect_threshold_code,
	// System side
	output logic             undervoltage_irq,
	output logic             undervoltage_reset_req
);
	typedef struct packed {
		logic       detector_enable;
		logic       reset_mode_select;
		logic [3:0] level_code;
		logic       irq;
		logic       rst_req;
		logic [7:0] rdata;
	} lvdc_state_t;

	lvdc_state_t st_reg;
	lvdc_state_t st_next;
	logic        below_sync;
	logic        undervoltage_flag;
	logic [7:0]  mode_view;
	logic [7:0]  mode_wval;

	lvdc_sync u_sync (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.async_in (cmp_below),
		.sync_out (below_sync)
	);

	// Flag reads zero while the comparator is disabled
	assign undervoltage_flag = st_reg.detector_enable & below_sync; // see [R21]
	assign mode_view = {st_reg.detector_enable, 5'h00,
		st_reg.reset_mode_select, undervoltage_flag}; // see [R18]

	always_comb begin
		st_next = st_reg;
		mode_wval = mode_view;
		if (reg_bit_wr) begin
			mode_wval[reg_bit_sel] = reg_wdata[0];
		end else begin
			mode_wval = reg_wdata;
		end
		if ((reg_wr || reg_bit_wr) && reg_addr == lvdc_pkg::ADDR_MODE) begin
			// Bits 6..2 stay zero, bit 0 is read-only
			st_next.detector_enable = mode_wval[lvdc_pkg::BIT_ENABLE];
			st_next.reset_mode_select =
				mode_wval[lvdc_pkg::BIT_RSTMODE]; // see [R18]
		end
		// Byte writes only; bit writes to the level register are ignored
		if (reg_wr && reg_addr == lvdc_pkg::ADDR_LEVEL) begin
			st_next.level_code = reg_wdata[3:0]; // see [R4]
		end
		// No mask here: the raw request may fire right after enabling and
		// while the comparator settles, so the system must mask it first
		st_next.irq = undervoltage_flag
			& ~st_reg.reset_mode_select; // see [R7], [R11], [R15], [R19]
		// Reset released as soon as supply recovers; no edge memory, so
		// setting the mode bit while supply is good gives no reset. The
		// system records the detector cause from this request
		st_next.rst_req = undervoltage_flag
			& st_reg.reset_mode_select; // see [R6], [R10], [R17]
		// A detector reset in progress blanks reads but keeps settings
		if (!detector_reset_n) begin
			st_next.rdata = 8'h00;
		end else if (reg_rd && reg_addr == lvdc_pkg::ADDR_MODE) begin
			st_next.rdata = mode_view;
		end else if (reg_rd && reg_addr == lvdc_pkg::ADDR_LEVEL) begin
			st_next.rdata = {4'h0, st_reg.level_code};
		end else begin
			st_next.rdata = 8'h00;
		end
	end

	// Settings survive a detector reset; only resetn clears them. The
	// request outputs start low after resetn, while the mask is set; a detector reset does not clear them
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin // see [R2], [R3], [R20]
			st_reg.detector_enable   <= lvdc_pkg::MODE_RESET_VAL[7];
			st_reg.reset_mode_select <= lvdc_pkg::MODE_RESET_VAL[1];
			st_reg.level_code        <= lvdc_pkg::LVL_RESET_VAL[3:0];
			st_reg.irq               <= 1'b0; // see [R14]
			st_reg.rst_req           <= 1'b0;
			st_reg.rdata             <= 8'h00;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata              = st_reg.rdata;
	assign cmp_enable             = st_reg.detector_enable;
	assign detect_threshold_code  = st_reg.level_code;
	assign undervoltage_irq       = st_reg.irq;
	assign undervoltage_reset_req = st_reg.rst_req;

	chk_irq_mode_only: assert property ( // see [R19]
		@(posedge clk_sys) disable iff (!resetn)
		undervoltage_irq |-> $past(st_reg.reset_mode_select) == 1'b0)
		else $error("irq raised in reset mode");

	chk_irq_follows_flag: assert property ( // see [R7]
		@(posedge clk_sys) disable iff (!resetn)
		(undervoltage_flag && !st_reg.reset_mode_select) |=> undervoltage_irq)
		else $error("irq missing while supply low");

	chk_rst_follows_flag: assert property ( // see [R6]
		@(posedge clk_sys) disable iff (!resetn)
		(undervoltage_flag && st_reg.reset_mode_select)
			|=> undervoltage_reset_req)
		else $error("reset missing while supply low");

	chk_rst_releases: assert property ( // see [R6]
		@(posedge clk_sys) disable iff (!resetn)
		!undervoltage_flag |=> !undervoltage_reset_req)
		else $error("reset held after supply recovered");

	chk_no_rst_good: assert property ( // see [R10]
		@(posedge clk_sys) disable iff (!resetn)
		($rose(st_reg.reset_mode_select) && !undervoltage_flag)
			|=> !undervoltage_reset_req)
		else $error("reset on mode set with good supply");

	chk_level_write: assert property ( // see [R4]
		@(posedge clk_sys) disable iff (!resetn)
		(reg_wr && reg_addr == lvdc_pkg::ADDR_LEVEL)
			|=> detect_threshold_code == $past(reg_wdata[3:0]))
		else $error("level write lost");

	chk_level_hold: assert property ( // see [R3]
		@(posedge clk_sys) disable iff (!resetn)
		!(reg_wr && reg_addr == lvdc_pkg::ADDR_LEVEL)
			|=> $stable(detect_threshold_code))
		else $error("level changed without write");

	chk_mode_readback: assert property ( // see [R18]
		@(posedge clk_sys) disable iff (!resetn)
		(reg_rd && reg_addr == lvdc_pkg::ADDR_MODE && detector_reset_n)
			|=> reg_rdata[6:2] == 5'h00
			&& reg_rdata[7] == $past(st_reg.detector_enable))
		else $error("mode readback wrong");

	chk_flag_disabled: assert property ( // see [R21]
		@(posedge clk_sys) disable iff (!resetn)
		!cmp_enable |-> !undervoltage_flag ##1 !undervoltage_irq)
		else $error("flag set while disabled");

	chk_rst_mode_only: assert property ( // see [R6]
		@(posedge clk_sys) disable iff (!resetn)
		undervoltage_reset_req |-> $past(st_reg.reset_mode_select))
		else $error("reset raised in interrupt mode");

	chk_rdata_idle: assert property ( // see [R18]
		@(posedge clk_sys) disable iff (!resetn)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without a read");

	chk_det_rst_blank: assert property ( // see [R3]
		@(posedge clk_sys) disable iff (!resetn)
		!detector_reset_n |=> reg_rdata == 8'h00)
		else $error("read data during detector reset");

	chk_det_rst_keep: assert property ( // see [R20]
		@(posedge clk_sys) disable iff (!resetn)
		(!detector_reset_n && !reg_wr && !reg_bit_wr)
			|=> $stable(cmp_enable) && $stable(st_reg.reset_mode_select))
		else $error("settings lost in detector reset");

	chk_mode_write: assert property ( // see [R18]
		@(posedge clk_sys) disable iff (!resetn)
		(reg_wr && reg_addr == lvdc_pkg::ADDR_MODE)
			|=> cmp_enable == $past(reg_wdata[lvdc_pkg::BIT_ENABLE]))
		else $error("enable write lost");

	chk_mode_bit_write: assert property ( // see [R12]
		@(posedge clk_sys) disable iff (!resetn)
		(reg_bit_wr && reg_addr == lvdc_pkg::ADDR_MODE && reg_bit_sel == 3'h1)
			|=> st_reg.reset_mode_select == $past(reg_wdata[0]))
		else $error("mode bit write lost");

	chk_level_readback: assert property ( // see [R4]
		@(posedge clk_sys) disable iff (!resetn)
		(reg_rd && reg_addr == lvdc_pkg::ADDR_LEVEL && detector_reset_n)
			|=> reg_rdata == {4'h0, $past(detect_threshold_code)})
		else $error("level readback wrong");

	chk_flag_readback: assert property ( // see [R18]
		@(posedge clk_sys) disable iff (!resetn)
		(reg_rd && reg_addr == lvdc_pkg::ADDR_MODE && detector_reset_n)
			|=> reg_rdata[0] == $past(undervoltage_flag))
		else $error("flag readback wrong");
endmodule

/* verilog/lvdc_pkg.sv */
// Package of addresses, field positions and reset values for the detector
package lvdc_pkg;
	localparam logic [15:0] ADDR_MODE      = 16'hff50;
	localparam logic [15:0] ADDR_LEVEL     = 16'hff51;
	localparam logic [7:0]  MODE_RESET_VAL = 8'h00;
	localparam logic [7:0]  LVL_RESET_VAL  = 8'h00;
	localparam int          BIT_ENABLE     = 7;
	localparam int          BIT_RSTMODE    = 1;
	localparam int          BIT_FLAG       = 0;
	localparam int          LVL_WIDTH      = 4;
	localparam logic [3:0]  LVL_MAX_CODE   = 4'h9;
	localparam int          SYNC_STAGES    = 2;
endpackage

/* verilog/lvdc_sync.sv */
// Two-stage synchroniser for the comparator output
`timescale 1ns/1ps
module lvdc_sync #(
	parameter int STAGES = lvdc_pkg::SYNC_STAGES
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Level in and out
	input  wire logic async_in,
	output logic      sync_out
);
	typedef struct packed {
		logic [STAGES-1:0] chain;
	} lvdc_sync_state_t;

	lvdc_sync_state_t st_reg;
	lvdc_sync_state_t st_next;

	always_comb begin
		st_next = st_reg;
		// Only the next stage reads the first one
		st_next.chain = {st_reg.chain[STAGES-2:0], async_in}; // see [R21]
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.chain[STAGES-1];
endmodule

/* verif/lvdc_top_tb.sv */
// Self-checking bench for the low-voltage detector control block
`timescale 1ns/1ps
module lvdc_top_tb;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        detector_reset_n = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_bit_wr = 1'b0;
	logic [2:0]  reg_bit_sel = 3'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_rd = 1'b0;
	logic        cmp_below = 1'b0;
	logic [7:0]  reg_rdata;
	logic        cmp_enable;
	logic [3:0]  detect_threshold_code;
	logic        undervoltage_irq;
	logic        undervoltage_reset_req;
	logic        rd_q = 1'b0;
	logic [7:0]  exp_q[$];
	logic [3:0]  lvl;
	int          err_total = 0;
	int          num_checks = 0;
	// Software settling wait of 0.2 ms at 8 ns per cycle
	localparam int SETTLE = 25000;

	always #4 clk_sys = ~clk_sys;

	lvdc_top u_dut (.clk_sys(clk_sys), .resetn(resetn),
		.detector_reset_n(detector_reset_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_bit_wr(reg_bit_wr), .reg_bit_sel(reg_bit_sel),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cmp_below(cmp_below), .cmp_enable(cmp_enable),
		.detect_threshold_code(detect_threshold_code),
		.undervoltage_irq(undervoltage_irq),
		.undervoltage_reset_req(undervoltage_reset_req));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d, errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Byte write, or with bw set a single-bit write of d[0] into bit b
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input logic bw, input logic [2:0] b);
		@(posedge clk_sys);
		reg_addr    <= a;
		reg_wdata   <= d;
		reg_wr      <= ~bw;
		reg_bit_wr  <= bw;
		reg_bit_sel <= b;
		@(posedge clk_sys);
		reg_wr     <= 1'b0;
		reg_bit_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask

	// Packed as {0, irq, reset request, enable, level code}; the wait covers
	// the two-stage synchroniser plus the output register
	task automatic outs(input logic [7:0] e);
		repeat (5) @(posedge clk_sys);
		chk({1'b0, undervoltage_irq, undervoltage_reset_req, cmp_enable,
			detect_threshold_code}, e);
	endtask

	// Read data lands one cycle after the strobe; oldest note is compared
	always @(posedge clk_sys) begin
		rd_q <= reg_rd;
		if (rd_q) begin
			chk(reg_rdata, exp_q.pop_front());
		end
	end

	initial begin
		repeat (80000) @(posedge clk_sys);
		err_total++;
		test_done();
	end

	initial begin
		lvl = 4'($urandom(88830) % 10);
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(lvdc_pkg::ADDR_MODE, 8'h00);
		rd(lvdc_pkg::ADDR_LEVEL, 8'h00);
		rd(16'hff52, 8'h00);
		wr(lvdc_pkg::ADDR_LEVEL, {4'h0, lvl}, 1'b0, 3'h0);
		// A bit write to the level register must leave the code alone
		wr(lvdc_pkg::ADDR_LEVEL, {7'h00, ~lvl[0]}, 1'b1, 3'h0);
		rd(lvdc_pkg::ADDR_LEVEL, {4'h0, lvl});
		wr(lvdc_pkg::ADDR_MODE, 8'h80, 1'b0, 3'h0);
		repeat (SETTLE) @(posedge clk_sys);
		rd(lvdc_pkg::ADDR_MODE, 8'h80);
		outs({4'h1, lvl});
		cmp_below <= 1'b1;
		outs({4'h5, lvl});
		rd(lvdc_pkg::ADDR_MODE, 8'h81);
		cmp_below <= 1'b0;
		outs({4'h1, lvl});
		rd(lvdc_pkg::ADDR_MODE, 8'h80);
		wr(lvdc_pkg::ADDR_MODE, 8'h01, 1'b1, 3'h1);
		outs({4'h1, lvl});
		cmp_below <= 1'b1;
		outs({4'h3, lvl});
		detector_reset_n <= 1'b0;
		rd(lvdc_pkg::ADDR_MODE, 8'h00);
		detector_reset_n <= 1'b1;
		outs({4'h3, lvl});
		rd(lvdc_pkg::ADDR_LEVEL, {4'h0, lvl});
		cmp_below <= 1'b0;
		outs({4'h1, lvl});
		wr(lvdc_pkg::ADDR_MODE, 8'h00, 1'b1, 3'h1);
		wr(lvdc_pkg::ADDR_MODE, 8'h00, 1'b1, 3'h7);
		outs({4'h0, lvl});
		// Bits 6..2 are written as ones to show they read back as zero
		wr(lvdc_pkg::ADDR_MODE, 8'hfd, 1'b0, 3'h0);
		repeat (SETTLE) @(posedge clk_sys);
		rd(lvdc_pkg::ADDR_MODE, 8'h80);
		cmp_below <= 1'b1;
		outs({4'h5, lvl});
		wr(lvdc_pkg::ADDR_MODE, 8'h00, 1'b1, 3'h7);
		outs({4'h0, lvl});
		wr(lvdc_pkg::ADDR_MODE, 8'h82, 1'b0, 3'h0);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		outs(8'h00);
		test_done();
	end
endmodule
